// [rtl/i2cmbe_pkg.sv]
// Package with the register map, field positions, reset values and timing of the byte engine.
// Overview of operation
// - Count drops by one per data byte.
// - Remaining count readable at any time.
// - Transmit count drops before the byte leaves.
// - Transmit starts on data word write.
// - Address first, then byte3 down to byte0.
// - Service flag requests words until count done.
// - Received bytes fill byte3 down to byte0.
// - Receive completes after exactly count bytes.
// - Four flags, each gated by its enable.
// - Complete flag set at transfer end.
// - Address not acknowledged: flag, go idle.
// - Data not acknowledged: flag, go idle.
// - Transmit complete and service flag encoding.
// - Receive complete and service flag encoding.
// - State field codes activity in bits 25:23.
// - Status bits 27 and 26 show low lines.
// - Status bit 22 shows transfer direction.
// - Status bits 15:8 mirror remaining count.
// - Address, direction and count field layout.
// - Control bits 25:22 clear the four flags.
// - Enable cleared resets and aborts all but the control, read data, synchroniser and receive buffer storage registers.
package i2cmbe_pkg;

    // Register indices on the register port.
    localparam logic [1:0] REG_ADDR_COUNT = 2'h0;
    localparam logic [1:0] REG_DATA       = 2'h1;
    localparam logic [1:0] REG_STATUS     = 2'h2;
    localparam logic [1:0] REG_CONTROL    = 2'h3;

    // Address/count field positions.
    localparam int ADDR_MSB  = 31;
    localparam int ADDR_LSB  = 25;
    localparam int DIR_BIT   = 24;
    localparam int COUNT_MSB = 15;
    localparam int COUNT_LSB = 8;

    // Status field positions.
    localparam int ST_COMPLETE  = 31;
    localparam int ST_SERVICE   = 30;
    localparam int ST_ADDR_NACK = 29;
    localparam int ST_DATA_NACK = 28;
    localparam int ST_SDA_LOW   = 27;
    localparam int ST_SCL_LOW   = 26;
    localparam int ST_STATE_MSB = 25;
    localparam int ST_STATE_LSB = 23;
    localparam int ST_DIR       = 22;

    // Control field positions.
    localparam int CT_IEN_MSB   = 31;
    localparam int CT_IEN_LSB   = 28;
    localparam int CT_CLR_MSB   = 25;
    localparam int CT_CLR_LSB   = 22;
    localparam int CT_ENABLE    = 0;

    // Flag order inside the four-bit flag vectors.
    localparam int FL_COMPLETE  = 3;
    localparam int FL_SERVICE   = 2;
    localparam int FL_ADDR_NACK = 1;
    localparam int FL_DATA_NACK = 0;

    // Codes of the state field.
    localparam logic [2:0] STC_IDLE  = 3'h0;
    localparam logic [2:0] STC_DONE  = 3'h2;
    localparam logic [2:0] STC_ADDR  = 3'h3;
    localparam logic [2:0] STC_BYTE3 = 3'h4;

    // Reset values and the number of bytes in a data word.
    localparam logic [31:0] RST_WORD    = 32'h0000_0000;
    localparam logic [7:0]  RST_COUNT   = 8'h00;
    localparam logic [3:0]  RST_FLAGS   = 4'h0;
    localparam logic [2:0]  WORD_BYTES  = 3'h4;

    // Bus timing: one quarter of a 100 kHz bit time.
    localparam int CLK_PERIOD_NS = 40;
    localparam int QUARTER_NS    = 2500;
    localparam int QUARTER_CYC   = (QUARTER_NS / CLK_PERIOD_NS < 1) ? 1
                                 : QUARTER_NS / CLK_PERIOD_NS;

endpackage : i2cmbe_pkg

// [rtl/i2cmbe_sync.sv]
// Two-stage synchroniser for levels that arrive from outside the clock domain.
`timescale 1ns/100ps
module i2cmbe_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage; lines idle high.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '1;
            sync_o <= '1;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : i2cmbe_sync

// [rtl/i2cmbe_fifo.sv]
// Small valid/ready buffer held in flip-flops.
`timescale 1ns/100ps
module i2cmbe_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input  wire logic             clk,
    input  wire logic             clr,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0]    wr_q, rd_q;
    logic [PW:0]      fill_q;
    logic             push, pop;

    // Full and empty come straight from the fill level.
    assign in_ready  = (fill_q != (PW+1)'(DEPTH));
    assign out_valid = (fill_q != '0);
    assign out_data  = mem_q[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    // Pointers wrap at the depth.
    always_ff @(posedge clk) begin
        if (clr) begin
            wr_q   <= '0;
            rd_q   <= '0;
            fill_q <= '0;
        end else begin
            if (push) begin
                wr_q <= (wr_q == PW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= (rd_q == PW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
            end
            fill_q <= fill_q + (PW+1)'(push) - (PW+1)'(pop);
        end
    end

    // Storage is written only on a push.
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end
endmodule : i2cmbe_fifo

// [rtl/i2cmbe_engine.sv]
// Single-master byte engine with host registers and open-drain bus pins.
`timescale 1ns/100ps
module i2cmbe_engine
    import i2cmbe_pkg::*;
#(
    parameter int QTR_CYCLES = i2cmbe_pkg::QUARTER_CYC
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic [1:0]  reg_sel,
    input  wire logic [31:0] reg_wdata,
    output logic      [31:0] reg_rdata,
    output logic             irq,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    input  wire logic        scl_i,
    output logic             scl_o,
    output logic             scl_oe
);
    typedef enum logic [3:0] {
        S_IDLE, S_START, S_ADDR, S_ACK_IN, S_WAIT, S_TX, S_RX, S_ACK_OUT, S_STOP, S_DONE
    } i2cmbe_state_e;

    i2cmbe_state_e st_q;
    logic [31:0] word_q;
    logic [7:0]  count_q, shift_q, fifo_out_data;
    logic [6:0]  addr_q, div_q;
    logic [3:0]  flags_q, ien_q, set_ev, clr_ev;
    logic [2:0]  tx_left_q, bit_cnt_q, state_code;
    logic [1:0]  rx_pos_q, phase_q, byte_pos_q;
    logic        dir_q, rx_full_q, enable_q, in_addr_q, nack_q, err_q, tick, step, blk_rst;
    logic        sda_s, scl_s, scl_low_q, sda_low_q, scl_low_d, sda_low_d;
    logic        wr_ac, wr_data, wr_ctl, rd_data, go_ev, load_ev, rx_byte_ev, nack_ev;
    logic        done_ev, svc_ev, fifo_in_ready, fifo_out_valid, fifo_out_ready;

    // Picks a byte of a word, byte3 at position 0.
    function automatic logic [7:0] word_byte(input logic [31:0] w, input logic [1:0] pos);
        word_byte = w[8*(3-int'(pos)) +: 8];
    endfunction : word_byte

    // Bus pin inputs are synchronised before any logic reads them.
    i2cmbe_sync #(.WIDTH(2)) u_sync (.clk(clk), .rst_n(rst_n), .async_i({sda_i, scl_i}),
        .sync_o({sda_s, scl_s}));

    // Received bytes queue here so a host that is slow to read loses nothing.
    i2cmbe_fifo #(.WIDTH(8), .DEPTH(2)) u_rx_buf (
        .clk       (clk),
        .clr       (blk_rst),
        .in_valid  (rx_byte_ev),
        .in_ready  (fifo_in_ready),
        .in_data   ({shift_q[6:0], sda_s}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_out_ready),
        .out_data  (fifo_out_data)
    );

    // Register port decode.
    assign wr_ac   = reg_wr && (reg_sel == REG_ADDR_COUNT);
    assign wr_data = reg_wr && (reg_sel == REG_DATA);
    assign wr_ctl  = reg_wr && (reg_sel == REG_CONTROL);
    assign rd_data = reg_rd && (reg_sel == REG_DATA);
    assign blk_rst = !rst_n || !enable_q;

    // Control register survives the block reset; it holds the enable itself.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            enable_q <= 1'b0;
            ien_q    <= RST_FLAGS;
        end else if (wr_ctl) begin
            enable_q <= reg_wdata[CT_ENABLE];
            ien_q    <= reg_wdata[CT_IEN_MSB:CT_IEN_LSB];
        end
    end

    // Quarter-bit tick divider; it only runs while the block is enabled.
    always_ff @(posedge clk) begin
        if (blk_rst || div_q == 7'(QTR_CYCLES - 1)) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end
    assign tick = !blk_rst && (div_q == 7'(QTR_CYCLES - 1));

    // A high clock phase is held while a slave stretches the clock low.
    assign step = tick && !(phase_q == 2'h2 && !scl_s);

    // Engine events.
    assign go_ev      = (st_q == S_IDLE) && ((wr_data && !dir_q)
                      || (wr_ac && reg_wdata[DIR_BIT]));
    assign load_ev    = (st_q == S_WAIT) && !dir_q && count_q != '0 && tx_left_q != '0;
    assign rx_byte_ev = (st_q == S_RX) && step && phase_q == 2'h2 && bit_cnt_q == '0;
    assign nack_ev    = (st_q == S_ACK_IN) && step && phase_q == 2'h3 && nack_q;
    assign done_ev    = (st_q == S_STOP) && step && phase_q == 2'h3 && !err_q
                      && !fifo_out_valid;

    // Bit-level sequencer: start, address, data, acknowledge, stop.
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            st_q <= S_IDLE;
            {phase_q, bit_cnt_q, shift_q, byte_pos_q, in_addr_q, nack_q, err_q} <= '0;
        end else begin
            if (step) begin
                phase_q <= phase_q + 1'b1;
            end
            unique case (st_q)
                S_IDLE: begin
                    phase_q <= '0;
                    err_q   <= 1'b0;
                    if (go_ev) begin
                        st_q <= S_START;
                    end
                end
                S_START: begin
                    if (step && phase_q == 2'h3) begin
                        st_q      <= S_ADDR;
                        shift_q   <= {addr_q, dir_q};
                        bit_cnt_q <= 3'h7;
                        in_addr_q <= 1'b1;
                        byte_pos_q <= '0;
                    end
                end
                S_ADDR, S_TX: begin
                    if (step && phase_q == 2'h3) begin
                        shift_q   <= {shift_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q - 1'b1;
                        if (bit_cnt_q == '0) begin
                            st_q <= S_ACK_IN;
                        end
                    end
                end
                S_ACK_IN: begin
                    if (step && phase_q == 2'h2) begin
                        nack_q <= sda_s;
                    end
                    if (step && phase_q == 2'h3) begin
                        if (nack_q) begin
                            st_q  <= S_STOP;
                            err_q <= 1'b1;
                        end else begin
                            st_q <= S_WAIT;
                        end
                        if (!in_addr_q) begin
                            byte_pos_q <= byte_pos_q + 1'b1;
                        end
                        in_addr_q <= 1'b0;
                    end
                end
                S_WAIT: begin
                    phase_q <= '0;
                    if (count_q == '0) begin
                        st_q <= S_STOP;
                    end else if (load_ev) begin
                        st_q      <= S_TX;
                        shift_q   <= word_byte(word_q, 2'(WORD_BYTES - tx_left_q));
                        bit_cnt_q <= 3'h7;
                    end else if (dir_q && fifo_in_ready) begin
                        st_q      <= S_RX;
                        bit_cnt_q <= 3'h7;
                    end
                end
                S_RX: begin
                    if (step && phase_q == 2'h2) begin
                        shift_q <= {shift_q[6:0], sda_s};
                    end
                    if (step && phase_q == 2'h3) begin
                        bit_cnt_q <= bit_cnt_q - 1'b1;
                        if (bit_cnt_q == '0) begin
                            st_q <= S_ACK_OUT;
                        end
                    end
                end
                S_ACK_OUT: begin
                    if (step && phase_q == 2'h3) begin
                        st_q       <= S_WAIT;
                        byte_pos_q <= byte_pos_q + 1'b1;
                    end
                end
                S_STOP: begin
                    if (step && phase_q == 2'h3) begin
                        if (err_q) begin
                            st_q <= S_IDLE;
                        end else if (done_ev) begin
                            st_q <= S_DONE;
                        end else begin
                            phase_q <= 2'h3;
                        end
                    end
                end
                S_DONE: begin
                    if (!flags_q[FL_COMPLETE]) begin
                        st_q <= S_IDLE;
                    end
                end
            endcase
        end
    end

    // Line drive for each state and quarter phase.
    always_comb begin
        scl_low_d = (phase_q == 2'h0) || (phase_q == 2'h3);
        sda_low_d = 1'b0;
        unique case (st_q)
            S_IDLE, S_DONE: scl_low_d = 1'b0;
            S_START: begin
                scl_low_d = 1'b0;
                sda_low_d = phase_q[1];
            end
            S_ADDR, S_TX:   sda_low_d = !shift_q[7];
            S_ACK_IN, S_RX: sda_low_d = 1'b0;
            S_ACK_OUT:      sda_low_d = (count_q != '0);
            S_WAIT:         scl_low_d = 1'b1;
            S_STOP: begin
                scl_low_d = (phase_q == 2'h0);
                sda_low_d = (phase_q != 2'h3);
            end
        endcase
    end

    // Open-drain pins driven from flip-flops.
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            scl_low_q <= 1'b0;
            sda_low_q <= 1'b0;
        end else begin
            scl_low_q <= scl_low_d;
            sda_low_q <= sda_low_d;
        end
    end
    assign scl_o  = 1'b0;
    assign sda_o  = 1'b0;
    assign scl_oe = scl_low_q;
    assign sda_oe = sda_low_q;

    // Address, direction and live byte count.
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            {addr_q, dir_q} <= '0;
            count_q <= RST_COUNT;
        end else if (wr_ac) begin
            addr_q  <= reg_wdata[ADDR_MSB:ADDR_LSB];
            dir_q   <= reg_wdata[DIR_BIT];
            count_q <= reg_wdata[COUNT_MSB:COUNT_LSB];
        end else if (load_ev || rx_byte_ev) begin
            count_q <= count_q - 1'b1;
        end
    end

    // Data word: host writes for transmit, packing of received bytes for receive.
    assign fifo_out_ready = !rx_full_q;
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            word_q    <= RST_WORD;
            tx_left_q <= '0;
            rx_pos_q  <= '0;
            rx_full_q <= 1'b0;
        end else begin
            if (wr_data) begin
                word_q    <= reg_wdata;
                tx_left_q <= dir_q ? 3'h0 : WORD_BYTES;
            end else if (load_ev) begin
                tx_left_q <= tx_left_q - 1'b1;
            end
            if (go_ev && dir_q) begin
                rx_pos_q  <= '0;
                rx_full_q <= 1'b0;
            end else if (fifo_out_valid && !rx_full_q) begin
                word_q[8*(3-int'(rx_pos_q)) +: 8] <= fifo_out_data;
                rx_pos_q  <= rx_pos_q + 1'b1;
                rx_full_q <= (rx_pos_q == 2'h3);
            end else if (rd_data && dir_q) begin
                rx_full_q <= 1'b0;
                rx_pos_q  <= '0;
            end
        end
    end

    // Service is needed when the transmit word runs dry or a received word fills.
    assign svc_ev = (load_ev && tx_left_q == 3'h1 && count_q != 8'h01)
                  || (fifo_out_valid && !rx_full_q && rx_pos_q == 2'h3
                      && count_q != '0);

    assign set_ev = {done_ev, svc_ev, nack_ev && in_addr_q, nack_ev && !in_addr_q};
    assign clr_ev = (wr_ctl ? reg_wdata[CT_CLR_MSB:CT_CLR_LSB] : 4'h0)
                  | {1'b0, wr_data || rd_data, 2'b00};

    // Sticky flags; a set in the same cycle as its clear wins.
    always_ff @(posedge clk) begin
        if (blk_rst) begin
            flags_q <= RST_FLAGS;
        end else begin
            flags_q <= (flags_q & ~clr_ev) | set_ev;
        end
    end

    // Request line is the level of any enabled flag.
    assign irq = |(flags_q & ien_q);

    // State field code for the status register.
    always_comb begin
        unique case (st_q)
            S_IDLE:          state_code = STC_IDLE;
            S_DONE:          state_code = STC_DONE;
            S_START, S_ADDR: state_code = STC_ADDR;
            S_ACK_IN:        state_code = in_addr_q ? STC_ADDR : STC_BYTE3 + 3'(byte_pos_q);
            default:         state_code = STC_BYTE3 + 3'(byte_pos_q);
        endcase
    end

    // Read data is registered one cycle after the read strobe.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            unique case (reg_sel)
                REG_ADDR_COUNT: reg_rdata <= {addr_q, dir_q, 8'h00, count_q, 8'h00};
                REG_DATA:       reg_rdata <= word_q;
                REG_STATUS:     reg_rdata <= {flags_q, !sda_s, !scl_s, state_code,
                                              dir_q, 6'h00, count_q, 8'h00};
                REG_CONTROL:    reg_rdata <= {ien_q, 27'h0, enable_q};
            endcase
        end
    end

endmodule : i2cmbe_engine

// [tb/i2cmbe_checker.sv]
// Checker of the byte engine's register port and bus pins.
`timescale 1ns/100ps
module i2cmbe_checker
    import i2cmbe_pkg::*;
#(
    parameter int QTR_CYCLES = 62
) (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [1:0]  reg_sel,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic        irq,
    input wire logic        sda_i,
    input wire logic        sda_o,
    input wire logic        sda_oe,
    input wire logic        scl_i,
    input wire logic        scl_o,
    input wire logic        scl_oe
);
    logic [31:0] ac_q;
    logic [3:0]  ien_q;
    logic        on_q;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Shadows of what the host last programmed; disabling wipes the address.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ac_q  <= '0;
            ien_q <= '0;
            on_q  <= 1'b0;
        end else if (reg_wr && reg_sel == REG_CONTROL) begin
            ien_q <= reg_wdata[31:28];
            on_q  <= reg_wdata[0];
            if (!reg_wdata[0]) ac_q <= '0;
        end else if (reg_wr && reg_sel == REG_ADDR_COUNT && on_q) begin
            ac_q <= reg_wdata;
        end
    end
    sequence st_rd;
        reg_rd && reg_sel == REG_STATUS;
    endsequence
    sequence ac_rd;
        reg_rd && reg_sel == REG_ADDR_COUNT;
    endsequence
    sequence quiet;
        ($stable(sda_i) && $stable(scl_i))[*4];
    endsequence
    irq_level_a: assert property (st_rd |=> (|(reg_rdata[31:28] & ien_q)) == $past(irq))
        else $error("irq mismatch");
    state_code_a: assert property (st_rd |=> reg_rdata[25:23] != 3'h1)
        else $error("reserved state code shown");
    done_count_a: assert property (st_rd |=> !reg_rdata[31] || reg_rdata[15:8] == 8'h00)
        else $error("complete with count left");
    serve_count_a: assert property (st_rd |=> !(reg_rdata[30] && !reg_rdata[22]) || reg_rdata[15:8] != 8'h00)
        else $error("service at count zero");
    nack_alone_a: assert property (st_rd |=> !(reg_rdata[31] && |reg_rdata[29:28]))
        else $error("complete with nack");
    line_level_a: assert property (quiet ##0 st_rd |=> reg_rdata[27:26] == ~$past({sda_i, scl_i}))
        else $error("line status wrong");
    dir_mirror_a: assert property (st_rd |=> reg_rdata[22] == ac_q[24])
        else $error("direction status wrong");
    addr_back_a: assert property (ac_rd |=> reg_rdata[31:24] == ac_q[31:24])
        else $error("address readback wrong");
    count_bound_a: assert property (ac_rd |=> reg_rdata[15:8] <= ac_q[15:8])
        else $error("count above programmed");
    abort_idle_a: assert property (reg_wr && reg_sel == REG_CONTROL && !reg_wdata[0] |-> ##3 !(sda_oe || scl_oe))
        else $error("pins driven after disable");
    scl_high_a: assert property ($fell(scl_oe) |-> !scl_oe[*3])
        else $error("short clock high");
endmodule : i2cmbe_checker

bind i2cmbe_engine i2cmbe_checker #(.QTR_CYCLES(QTR_CYCLES)) i_chk (.clk(clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq(irq), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe));

// [tb/i2cmbe_slave.sv]
// Behavioural slave on the far side of the bus.
`timescale 1ns/100ps
module i2cmbe_slave #(
    parameter logic [6:0] ADDR = 7'h2a
) (
    input  wire logic       scl,
    input  wire logic       sda,
    input  wire logic       nack_data,
    input  wire logic       stretch,
    output logic            sda_pull = 1'b0,
    output logic            scl_pull = 1'b0,
    output logic            wstb     = 1'b0,
    output logic      [7:0] wbyte    = 8'h00,
    output int              rcnt     = 0
);
    int         n    = 0;
    logic [1:0] st   = 2'd3;
    logic [7:0] sh   = 8'h00, so = 8'h00, nb = 8'h5a;
    logic       mack = 1'b0;
    // Start opens framing, stop closes it; both free the data line.
    always @(sda) if (scl === 1'b1) begin
        n = 0;
        st = sda ? 2'd3 : 2'd0;
        sda_pull = 1'b0;
    end
    // Bits are taken while the clock is high.
    always @(posedge scl) begin
        if (n < 8) sh = {sh[6:0], sda};
        else mack = !sda;
        n = n + 1;
    end
    // Acknowledge, store and send on the falling clock.
    always @(negedge scl) begin
        wstb = 1'b0;
        if (n == 8 && st == 2'd0) begin
            sda_pull = (sh[7:1] == ADDR);
            st = !sda_pull ? 2'd3 : sh[0] ? 2'd2 : 2'd1;
        end else if (n == 8 && st == 2'd1) begin
            sda_pull = !nack_data;
            wbyte = sh;
            wstb = 1'b1;
        end else if (n == 9) begin
            n = 0;
            sda_pull = 1'b0;
            if (st == 2'd2 && !mack) st = 2'd3;
            if (st == 2'd2) begin
                so = nb;
                nb = nb + 8'h11;
                rcnt = rcnt + 1;
                sda_pull = !so[7];
            end
        end else if (st == 2'd2 && n < 8 && n > 0) begin
            so = {so[6:0], 1'b0};
            sda_pull = !so[7];
        end else if (st == 2'd2) sda_pull = 1'b0;
    end
    // A slow slave holds the clock low for a while after each fall.
    always @(negedge scl) if (stretch) begin
        scl_pull = 1'b1;
        #600 scl_pull = 1'b0;
    end
endmodule : i2cmbe_slave

// [tb/i2c_master_byte_engine_tb.sv]
// Self-checking bench of the byte engine against a slave model.
`timescale 1ns/100ps
module i2c_master_byte_engine_tb;
    import i2cmbe_pkg::*;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, rd_d = 0;
    logic [1:0]  reg_sel = 0;
    logic [31:0] reg_wdata = 0, reg_rdata, w1, w2;
    logic        irq, sda_o, sda_oe, scl_o, scl_oe, sda_pull, scl_pull, wstb;
    logic        nack_data = 0, stretch = 0;
    logic [7:0]  wbyte;
    wire         sda_w = (sda_oe ? sda_o : 1'b1) & !sda_pull;
    wire         scl_w = (scl_oe ? scl_o : 1'b1) & !scl_pull;
    int          rcnt, err_count = 0, checked = 0, cyc = 0, seed = 16147;
    logic [31:0] eq[$], mq[$];
    logic [7:0]  bq[$];
    always #20 clk = ~clk;
    i2cmbe_engine #(.QTR_CYCLES(2)) i_dut (.clk(clk), .rst_n(rst_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .irq(irq), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe), .scl_i(scl_w),
        .scl_o(scl_o), .scl_oe(scl_oe));
    i2cmbe_slave i_slv (.scl(scl_w), .sda(sda_w), .nack_data(nack_data), .stretch(stretch),
        .sda_pull(sda_pull), .scl_pull(scl_pull), .wstb(wstb), .wbyte(wbyte), .rcnt(rcnt));
    task automatic bad(input string s);
        err_count++;
        $display("[ERR] %0t %s", $time, s);
    endtask : bad
    task automatic cmp(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
        checked++;
        if ((g & m) !== (e & m)) bad($sformatf("got %h want %h", g, e));
    endtask : cmp
    task automatic wr(input logic [1:0] s, input logic [31:0] d);
        @(negedge clk);
        {reg_wr, reg_sel, reg_wdata} = {1'b1, s, d};
        @(negedge clk);
        reg_wr = 0;
    endtask : wr
    task automatic rd(input logic [1:0] s, input logic [31:0] e, input logic [31:0] m);
        @(negedge clk);
        {reg_rd, reg_sel} = {1'b1, s};
        eq.push_back(e);
        mq.push_back(m);
        @(negedge clk);
        reg_rd = 0;
    endtask : rd
    task automatic poll(input int b);
        for (int k = 0; k < 4000; k++) begin
            rd(REG_STATUS, 32'h0, 32'h0);
            if (reg_rdata[b] === 1'b1) return;
        end
        bad("flag never rose");
    endtask : poll
    function automatic logic [31:0] ac(input logic [6:0] a, input logic d, input logic [7:0] n);
        return {a, d, 8'h00, n, 8'h00};
    endfunction : ac
    task automatic final_report();
        $display("checked %0d err_count %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Read answers and slave bytes are checked against the oldest notes.
    always @(posedge clk) rd_d <= reg_rd;
    always @(negedge clk) if (rd_d) cmp(eq.pop_front(), mq.pop_front(), reg_rdata);
    always @(posedge wstb) cmp({24'h0, bq.pop_front()}, 32'hff, {24'h0, wbyte});
    // A hung run is cut short.
    always @(posedge clk) if (++cyc == 20000) begin
        bad("timeout");
        final_report();
    end
    // Reset, then transmit, receive, both nack cases and an abort.
    initial begin
        repeat (10) @(negedge clk);
        rst_n = 1;
        rd(REG_STATUS, RST_WORD, '1);
        wr(REG_CONTROL, 32'hf000_0001);
        w1 = $random(seed);
        w2 = $random(seed);
        for (int i = 3; i >= 0; i--) bq.push_back(w1[i*8 +: 8]);
        bq.push_back(w2[31:24]);
        wr(REG_ADDR_COUNT, ac(7'h2a, 1'b0, 8'd5));
        wr(REG_DATA, w1);
        poll(ST_SERVICE);
        rd(REG_STATUS, 32'h4000_0100, 32'hf040_ff00);
        cmp(32'h1, 32'h1, {31'h0, irq});
        wr(REG_DATA, w2);
        poll(ST_COMPLETE);
        rd(REG_STATUS, 32'h8100_0000, 32'hb380_ff00);
        rd(REG_ADDR_COUNT, ac(7'h2a, 1'b0, 8'd0), '1);
        wr(REG_CONTROL, 32'h0000_0001);
        cmp(32'h0, 32'h1, {31'h0, irq});
        wr(REG_CONTROL, 32'h0200_0001);
        rd(REG_STATUS, 32'h0, 32'hf380_0000);
        stretch = 1;
        wr(REG_ADDR_COUNT, ac(7'h2a, 1'b1, 8'd6));
        poll(ST_SERVICE);
        rd(REG_STATUS, 32'h4040_0000, 32'hc040_0000);
        rd(REG_DATA, 32'h5a6b_7c8d, '1);
        poll(ST_COMPLETE);
        rd(REG_DATA, 32'h9eaf_0000, 32'hffff_0000);
        cmp(32'd6, '1, 32'(rcnt));
        stretch = 0;
        wr(REG_CONTROL, 32'h0200_0001);
        wr(REG_ADDR_COUNT, ac(7'h11, 1'b0, 8'd1));
        wr(REG_DATA, $random(seed));
        poll(ST_ADDR_NACK);
        repeat (40) @(negedge clk);
        rd(REG_STATUS, 32'h2000_0000, 32'hf380_0000);
        wr(REG_CONTROL, 32'h0080_0001);
        nack_data = 1;
        w1 = $random(seed);
        bq.push_back(w1[31:24]);
        wr(REG_ADDR_COUNT, ac(7'h2a, 1'b0, 8'd2));
        wr(REG_DATA, w1);
        poll(ST_DATA_NACK);
        repeat (40) @(negedge clk);
        rd(REG_STATUS, 32'h1000_0000, 32'hf380_0000);
        wr(REG_CONTROL, 32'h0040_0001);
        rd(REG_STATUS, 32'h0, 32'hf000_0000);
        nack_data = 0;
        wr(REG_ADDR_COUNT, ac(7'h2a, 1'b0, 8'd4));
        wr(REG_DATA, $random(seed));
        repeat (20) @(negedge clk);
        wr(REG_CONTROL, 32'h0);
        repeat (4) @(negedge clk);
        rd(REG_STATUS, RST_WORD, '1);
        rd(REG_ADDR_COUNT, RST_WORD, '1);
        final_report();
    end
endmodule : i2c_master_byte_engine_tb
